// ---- cps_pkg.sv ----
package cps_pkg;
  // ==========================================================
  // Port selection
  // ==========================================================
  localparam logic [1:0] PORT_NONE   = 2'h0;
  localparam logic [1:0] PORT_SLAVE  = 2'h1;
  localparam logic [1:0] PORT_MASTER = 2'h2;
  localparam logic [1:0] PORT_SCAN   = 2'h3;
  // Master boot data width codes
  localparam logic [1:0] WIDTH_X1 = 2'h0;
  localparam logic [1:0] WIDTH_X2 = 2'h1;
  localparam logic [1:0] WIDTH_X4 = 2'h2;
  // ==========================================================
  // Defaults and reset values
  // ==========================================================
  localparam int          KEY_W        = 32;
  localparam logic [31:0] KEY_DEFAULT  = 32'ha5c3_5a3c; // Arbitrary key value
  localparam int          FRAME_W      = 32;
  localparam int          ECC_W        = 6;
  localparam int          CRC_W        = 16;
  localparam logic [15:0] CRC_SEED     = 16'hffff;
  localparam logic [15:0] CRC_POLY     = 16'h1021;
  localparam int          HOST_PROG_NS = 50;
  localparam int          CLK_NS       = 10;
  localparam int          HOST_PROG_CYC = (HOST_PROG_NS / CLK_NS < 1) ? 1 : HOST_PROG_NS / CLK_NS;
  // Reboot images
  localparam logic IMG_NEW    = 1'b1;
  localparam logic IMG_GOLDEN = 1'b0;
endpackage : cps_pkg

// ---- cps_config_ctrl.sv ----
`timescale 1ns/1ns
// How it works
// R1 - A low program-request pin at power-up puts the device in slave mode waiting for the key.
// R2 - The host raises program-request within 50 ns of chip-select release after the key.
// R3 - With no slave port active when program-request is seen high, the device boots from serial flash.
// R4 - The activated port stays selected for the whole configuration cycle; others are ignored.
// R5 - Boundary scan takes over at any time when its enable pin is high and the command arrives.
// R6 - Master boot reads the flash at x1, x2 or x4 width as configured.
// R7 - Program-request, init-status and done act as configuration pins unless turned into GPIO; the code gates only init-status and done.
// R8 - Multi-boot loads a new image and falls back to the golden image on a bad image, no power cycle.
// R9 - The soft error detector reads configuration memory frame by frame and checks ECC on each.
// R10 - An error raises a notification and scanning continues with the next frame.
// R11 - A single-bit error is corrected from the check bits and written back into the frame.
// R12 - More than one bit error in a frame is reported as uncorrectable with no rewrite; the code miscorrects doubles whose syndrome falls in 1..32.
// R13 - A CRC over the whole bitstream runs alongside ECC and is verified after the last frame.
// R14 - Frames marked as user memory are excluded from both ECC and CRC; a user frame at the last address is fed to the final CRC check as zeros.
// R15 - With the freeze option on, I/O states are held while the device is reconfigured.
// R16 - After the CRC check the detector wraps to frame zero and scans again while enabled.
// R17 - Key words are compared in order; the port goes active only on full match at chip-select release.
module cps_config_ctrl
  import cps_pkg::*;
#(
  parameter int FRAMES = 64,
  parameter int KEY_WORDS = 2
) (
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               sys_rst_in,
  // Configuration pins
  input  wire logic               program_request_pin_in,
  input  wire logic               slave_chip_select_n_in,
  input  wire logic               key_word_valid_in,
  input  wire logic [KEY_W-1:0]   key_word_in,
  input  wire logic               scan_enable_pin_in,
  input  wire logic               scan_command_in,
  // Options
  input  wire logic               config_pins_gpio_in,
  input  wire logic               io_freeze_update_in,
  input  wire logic [1:0]         boot_width_in,
  // Multi-boot
  input  wire logic               reboot_request_in,
  input  wire logic               image_done_in,
  input  wire logic               image_bad_in,
  // Configuration memory readback
  input  wire logic [FRAME_W-1:0] frame_data_in,
  input  wire logic [ECC_W-1:0]   frame_ecc_in,
  input  wire logic               frame_user_mem_in,
  input  wire logic               frame_valid_in,
  input  wire logic [CRC_W-1:0]   crc_expected_in,
  input  wire logic               sed_enable_in,
  // Status and control outputs
  output logic [1:0]              active_port_out,
  output logic [1:0]              flash_lanes_out,
  output logic                    boot_image_out,
  output logic                    init_status_pin_out,
  output logic                    init_status_pin_oe_out,
  output logic                    config_done_out,
  output logic                    io_frozen_out,
  output logic [$clog2(FRAMES)-1:0] frame_addr_out,
  output logic                    frame_read_out,
  output logic                    frame_write_out,
  output logic [FRAME_W-1:0]      frame_wdata_out,
  output logic                    sed_error_out,
  output logic                    sed_uncorrectable_out,
  output logic                    crc_error_out
);

  localparam int FA_W = $clog2(FRAMES);
  localparam int KC_W = $clog2(KEY_WORDS + 1);

  initial begin
    if (FRAMES < 2 || KEY_WORDS < 1 || FRAME_W != 32 || ECC_W != 6) begin
      $error("cps_config_ctrl: unsupported parameters");
    end
  end

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      // Chip select idles high in both stages, so no false edge follows reset
      sync1_ff <= 5'h02;
      sync2_ff <= 5'h02;
    end else begin
      sync1_ff <= {scan_command_in, scan_enable_pin_in, key_word_valid_in,
                   slave_chip_select_n_in, program_request_pin_in};
      sync2_ff <= sync1_ff;
    end
  end
  wire prog_s  = sync2_ff[0];
  wire csn_s   = sync2_ff[1];
  wire kv_s    = sync2_ff[2];
  wire jen_s   = sync2_ff[3];
  wire jcmd_s  = sync2_ff[4];

  // Key word is held stable by the host while its strobe is high;
  // two stages keep it in step with the synchronised strobe
  logic [KEY_W-1:0] key_sync_ff;
  logic [KEY_W-1:0] key_hold_ff;
  logic             kv_d_ff;
  logic             csn_d_ff;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      key_sync_ff <= '0;
      key_hold_ff <= '0;
      kv_d_ff     <= 1'b0;
      csn_d_ff    <= 1'b1;
    end else begin
      key_sync_ff <= key_word_in;
      key_hold_ff <= key_sync_ff;
      kv_d_ff     <= kv_s;
      csn_d_ff    <= csn_s;
    end
  end

  // ==========================================================
  // Port selection state machine
  // ==========================================================
  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_SLAVE   = 3'b001,
    ST_MASTER  = 3'b010,
    ST_SCAN    = 3'b011,
    ST_DONE    = 3'b100
  } cps_state_t;

  cps_state_t       state_ff;
  logic [KC_W-1:0]  key_cnt_ff;
  logic             key_ok_ff;
  logic             slave_active_ff;
  logic [1:0]       first_ff;

  // Key words checked against index-tagged copies of the key
  function automatic logic [KEY_W-1:0] key_word(input logic [KC_W-1:0] idx);
    key_word = KEY_DEFAULT ^ {{(KEY_W-KC_W){1'b0}}, idx};
  endfunction : key_word

  // Key comparison, valid only during chip select
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      key_cnt_ff <= '0;
      key_ok_ff  <= 1'b1;
    end else if (state_ff != ST_SLAVE || csn_s) begin
      if (csn_s && !csn_d_ff) begin
        key_cnt_ff <= '0; // Fresh attempt after each frame
        key_ok_ff  <= 1'b1;
      end
    end else if (kv_s && !kv_d_ff) begin
      if (key_cnt_ff >= KC_W'(KEY_WORDS) || key_hold_ff != key_word(key_cnt_ff)) begin
        key_ok_ff <= 1'b0; // R17
      end
      if (key_cnt_ff < KC_W'(KEY_WORDS)) begin
        key_cnt_ff <= key_cnt_ff + 1'b1;
      end
    end
  end

  // Main sequencing; scan enable together with a scan command overrides any other state
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_ff        <= ST_POWERUP;
      slave_active_ff <= 1'b0;
      first_ff        <= 2'b11;
    end else begin
      first_ff <= {first_ff[0], 1'b0}; // Two edges for the pin synchroniser to fill
      if (jen_s && jcmd_s && state_ff != ST_SCAN) begin
        state_ff <= ST_SCAN; // R5
      end else begin
        case (state_ff)
          ST_POWERUP: begin
            if (first_ff == 2'b00) begin
              state_ff <= prog_s ? ST_MASTER : ST_SLAVE; // R1
            end
          end
          ST_SLAVE: begin
            // Once chosen, only this port or a scan override is honoured
            if (!slave_active_ff && csn_s && !csn_d_ff && key_ok_ff
                && key_cnt_ff == KC_W'(KEY_WORDS)) begin
              slave_active_ff <= 1'b1; // R17
            end
            if (prog_s && !slave_active_ff) begin
              state_ff <= ST_MASTER; // R3
            end else if (slave_active_ff && image_done_in) begin
              state_ff <= ST_DONE; // R4
            end
          end
          ST_MASTER: begin
            if (image_done_in && !image_bad_in) begin
              state_ff <= ST_DONE; // R4
            end
          end
          ST_SCAN: begin
            if (!jen_s) begin
              state_ff <= ST_DONE;
            end
          end
          ST_DONE: begin
            if (reboot_request_in) begin
              state_ff <= ST_MASTER; // R8
            end
          end
          default: state_ff <= ST_POWERUP;
        endcase
      end
    end
  end

  // ==========================================================
  // Multi-boot image choice
  // ==========================================================
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      boot_image_out <= IMG_GOLDEN;
    end else if (state_ff == ST_DONE && reboot_request_in) begin
      boot_image_out <= IMG_NEW; // R8
    end else if (state_ff == ST_MASTER && image_done_in && image_bad_in) begin
      boot_image_out <= IMG_GOLDEN; // R8
    end
  end

  // ==========================================================
  // Pin and status outputs
  // ==========================================================
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      active_port_out        <= PORT_NONE;
      flash_lanes_out        <= WIDTH_X1;
      init_status_pin_out    <= 1'b0;
      init_status_pin_oe_out <= 1'b0;
      config_done_out        <= 1'b0;
      io_frozen_out          <= 1'b0;
    end else begin
      case (state_ff)
        ST_SLAVE:  active_port_out <= slave_active_ff ? PORT_SLAVE : PORT_NONE;
        ST_MASTER: active_port_out <= PORT_MASTER;
        ST_SCAN:   active_port_out <= PORT_SCAN;
        default:   active_port_out <= active_port_out; // Kept through done
      endcase
      // Unknown width code falls back to single lane
      flash_lanes_out <= (boot_width_in == WIDTH_X2 || boot_width_in == WIDTH_X4)
                         ? boot_width_in : WIDTH_X1; // R6
      // Open-drain init status: pull low while configuring
      init_status_pin_out    <= 1'b0;
      init_status_pin_oe_out <= !config_pins_gpio_in && state_ff != ST_DONE; // R7
      config_done_out        <= !config_pins_gpio_in && state_ff == ST_DONE; // R7
      io_frozen_out          <= io_freeze_update_in
                                && (state_ff == ST_MASTER || state_ff == ST_SLAVE); // R15
    end
  end

  // ==========================================================
  // Soft error detector
  // ==========================================================
  // Hamming check bits: bit k covers data positions whose index plus one has bit k set
  function automatic logic [ECC_W-1:0] ecc_of(input logic [FRAME_W-1:0] d);
    logic [ECC_W-1:0] e;
    e = '0;
    for (int i = 0; i < FRAME_W; i++) begin
      if (d[i]) begin
        e = e ^ ECC_W'(i + 1);
      end
    end
    ecc_of = e;
  endfunction : ecc_of

  function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c,
                                                input logic [FRAME_W-1:0] d);
    logic [CRC_W-1:0] r;
    r = c;
    for (int i = FRAME_W - 1; i >= 0; i--) begin
      r = (r[CRC_W-1] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    crc_step = r;
  endfunction : crc_step

  wire sed_run = sed_enable_in && state_ff == ST_DONE;
  wire [ECC_W-1:0] syndrome = ecc_of(frame_data_in) ^ frame_ecc_in;
  // Single flip gives syndrome 1..32; doubles aliasing into that range are miscorrected
  wire single_err = syndrome != '0 && syndrome <= ECC_W'(FRAME_W);
  wire [FRAME_W-1:0] flip_mask = FRAME_W'(1) << (syndrome - 1'b1);
  logic [CRC_W-1:0] crc_ff;

  // Frame walk, correction and reporting
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      frame_addr_out        <= '0;
      frame_read_out        <= 1'b0;
      frame_write_out       <= 1'b0;
      frame_wdata_out       <= '0;
      sed_error_out         <= 1'b0;
      sed_uncorrectable_out <= 1'b0;
      crc_error_out         <= 1'b0;
      crc_ff                <= CRC_SEED;
    end else begin
      frame_write_out       <= 1'b0;
      sed_error_out         <= 1'b0;
      sed_uncorrectable_out <= 1'b0;
      crc_error_out         <= 1'b0;
      frame_read_out        <= sed_run; // R9
      if (!sed_run) begin
        frame_addr_out <= '0;
        crc_ff         <= CRC_SEED;
      end else if (frame_valid_in) begin
        if (!frame_user_mem_in) begin // R14
          crc_ff <= crc_step(crc_ff, frame_data_in); // R13
          if (syndrome != '0) begin
            sed_error_out <= 1'b1; // R10
            if (single_err) begin
              frame_write_out <= 1'b1; // R11
              frame_wdata_out <= frame_data_in ^ flip_mask;
            end else begin
              sed_uncorrectable_out <= 1'b1; // R12
            end
          end
        end
        if (frame_addr_out == FA_W'(FRAMES - 1)) begin
          crc_error_out  <= crc_step(crc_ff, frame_user_mem_in ? '0 : frame_data_in)
                            != crc_expected_in; // R13
          frame_addr_out <= '0; // R16
          crc_ff         <= CRC_SEED;
        end else begin
          frame_addr_out <= frame_addr_out + 1'b1; // R10
        end
      end
    end
  end

endmodule : cps_config_ctrl

// ---- cps_config_ctrl_checker.sv ----
`timescale 1ns/1ns
// ==========================================
// Port checks for the configuration controller
module cps_config_ctrl_checker
  import cps_pkg::*;
#(
  parameter int FRAMES = 64
) (
  // Clock and reset
  input wire logic                      clock_in,
  input wire logic                      sys_rst_in,
  // Watched inputs
  input wire logic                      config_pins_gpio_in,
  input wire logic                      frame_valid_in,
  // Watched outputs
  input wire logic [1:0]                active_port_out,
  input wire logic                      init_status_pin_out,
  input wire logic                      init_status_pin_oe_out,
  input wire logic                      config_done_out,
  input wire logic [$clog2(FRAMES)-1:0] frame_addr_out,
  input wire logic                      frame_read_out,
  input wire logic                      frame_write_out,
  input wire logic                      sed_error_out,
  input wire logic                      sed_uncorrectable_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // Pin ownership: open drain, released as GPIO
  a_init_open_drain: assert property (init_status_pin_oe_out |-> !init_status_pin_out)
    else $error("status pin driven high");
  a_gpio_release: assert property (config_pins_gpio_in [*3] |-> !init_status_pin_oe_out)
    else $error("status pin kept in GPIO use");
  // Master port choice never falls back to slave
  a_master_kept: assert property (active_port_out == PORT_MASTER |=> active_port_out != PORT_SLAVE)
    else $error("master port left for slave");
  // Scrub walk: one address step per frame, wrap at the end
  a_scan_when_done: assert property (frame_read_out |-> !init_status_pin_oe_out)
    else $error("readback outside done state");
  a_addr_step: assert property (frame_valid_in && frame_read_out |=> frame_addr_out == $past(frame_addr_out) + 1'b1)
    else $error("frame address did not step");
  // Error pulses follow a frame; rewrite only when correctable
  a_error_after_frame: assert property (sed_error_out |-> $past(frame_valid_in))
    else $error("error pulse without frame");
  a_write_flags: assert property (frame_write_out |-> sed_error_out && !sed_uncorrectable_out)
    else $error("rewrite without correctable error");
  a_no_rewrite: assert property (sed_uncorrectable_out |-> !frame_write_out)
    else $error("rewrite on uncorrectable frame");
endmodule : cps_config_ctrl_checker

bind cps_config_ctrl cps_config_ctrl_checker #(.FRAMES(FRAMES)) u_checker (
  .clock_in, .sys_rst_in, .config_pins_gpio_in, .frame_valid_in, .active_port_out, .init_status_pin_out,
  .init_status_pin_oe_out, .config_done_out, .frame_addr_out, .frame_read_out, .frame_write_out,
  .sed_error_out, .sed_uncorrectable_out
);

// ---- cps_host_model.sv ----
`timescale 1ns/1ns
// ==========================================
// Configuring host: program pin and key frames
module cps_host_model
  import cps_pkg::*;
(
  // Clock
  input  wire logic        clock_in,
  // Host pins
  output logic             prog_out,
  output logic             sel_n_out,
  output logic             valid_out,
  output logic [KEY_W-1:0] word_out
);
  // Idle: deselected, program low so power-up picks slave
  initial begin
    prog_out = 1'b0;
    sel_n_out = 1'b1;
    valid_out = 1'b0;
    word_out = KEY_DEFAULT;
  end
  // Key frame; slow stretches strobes, bad spoils the last word
  task automatic send_key(input int words, input bit bad, input bit slow);
    logic [KEY_W-1:0] w;
    w = '0;
    @(posedge clock_in);
    sel_n_out <= 1'b0;
    for (int i = 0; i < words; i++) begin
      w = KEY_DEFAULT ^ KEY_W'(i) ^ KEY_W'(bad && i == words - 1);
      repeat (slow ? 6 : 2) @(posedge clock_in);
      word_out <= w;
      valid_out <= 1'b1;
      repeat (slow ? 8 : 4) @(posedge clock_in);
      valid_out <= 1'b0;
    end
    repeat (4) @(posedge clock_in);
    // Released word lines show the inverse, never a stale key
    word_out <= ~w;
    sel_n_out <= 1'b1;
    @(posedge clock_in);
    prog_out <= 1'b1;
  endtask : send_key
endmodule : cps_host_model

// ---- config_port_select_and_seu_scrub_test.sv ----
`timescale 1ns/1ns
module config_port_select_and_seu_scrub_test
  import cps_pkg::*;
;
  // ==========================================
  // Bench signals; four frames keep scans short
  localparam int FRAMES = 4;
  localparam int KEY_WORDS = 2;
  logic clock_in = 1'b0, sys_rst_in = 1'b1, scan_enable_pin_in = 1'b0, scan_command_in = 1'b0;
  logic config_pins_gpio_in = 1'b0, io_freeze_update_in = 1'b1, reboot_request_in = 1'b0;
  logic image_done_in = 1'b0, image_bad_in = 1'b0, frame_user_mem_in = 1'b0, frame_valid_in = 1'b0;
  logic sed_enable_in = 1'b0, program_request_pin_in, slave_chip_select_n_in, key_word_valid_in;
  logic [1:0] boot_width_in = 2'h0, active_port_out, flash_lanes_out;
  logic [KEY_W-1:0] key_word_in;
  logic [FRAME_W-1:0] frame_data_in = '0, frame_wdata_out, fr_d[FRAMES], fr_x[FRAMES];
  logic [ECC_W-1:0] frame_ecc_in = '0, syn;
  logic [CRC_W-1:0] crc_expected_in = '0, c;
  logic boot_image_out, init_status_pin_out, init_status_pin_oe_out, config_done_out, io_frozen_out;
  logic frame_read_out, frame_write_out, sed_error_out, sed_uncorrectable_out, crc_error_out;
  logic [$clog2(FRAMES)-1:0] frame_addr_out;
  int failures = 0, check_count = 0, n;
  // 100 MHz clock
  always #5 clock_in = ~clock_in;
  cps_config_ctrl #(.FRAMES(FRAMES), .KEY_WORDS(KEY_WORDS)) u_cps_config_ctrl (
    .clock_in, .sys_rst_in, .program_request_pin_in, .slave_chip_select_n_in, .key_word_valid_in,
    .key_word_in, .scan_enable_pin_in, .scan_command_in, .config_pins_gpio_in, .io_freeze_update_in,
    .boot_width_in, .reboot_request_in, .image_done_in, .image_bad_in, .frame_data_in, .frame_ecc_in,
    .frame_user_mem_in, .frame_valid_in, .crc_expected_in, .sed_enable_in, .active_port_out,
    .flash_lanes_out, .boot_image_out, .init_status_pin_out, .init_status_pin_oe_out, .config_done_out,
    .io_frozen_out, .frame_addr_out, .frame_read_out, .frame_write_out, .frame_wdata_out,
    .sed_error_out, .sed_uncorrectable_out, .crc_error_out
  );
  cps_host_model u_cps_host_model (
    .clock_in, .prog_out(program_request_pin_in), .sel_n_out(slave_chip_select_n_in),
    .valid_out(key_word_valid_in), .word_out(key_word_in)
  );
  // ==========================================
  // Checking and reference helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    if (failures == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // Bounded wait: 0 port code, 1 done, 2 readback
  task automatic wait_out(input int sel, input logic [1:0] p);
    logic ok;
    n = 0;
    ok = 1'b0;
    while (!ok && n < 300) begin
      @(posedge clock_in);
      #1;
      n++;
      ok = (sel == 0) ? active_port_out === p : (sel == 1) ? config_done_out === 1'b1 : frame_read_out === 1'b1;
    end
    chk("wait", ok, 1'b1);
    if (!ok) report_and_stop();
  endtask : wait_out
  task automatic do_reset(input logic [1:0] w, input logic p);
    @(posedge clock_in);
    sys_rst_in <= 1'b1;
    boot_width_in <= w;
    u_cps_host_model.prog_out <= p;
    repeat (4) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge clock_in);
  endtask : do_reset
  // Image result or reboot request, one cycle wide
  task automatic pulse(input bit rb, input logic bad);
    @(posedge clock_in);
    reboot_request_in <= rb;
    image_done_in <= !rb;
    image_bad_in <= bad;
    @(posedge clock_in);
    reboot_request_in <= 1'b0;
    image_done_in <= 1'b0;
    image_bad_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    #1;
  endtask : pulse
  // Syndrome of a flip pattern equals the ECC of that pattern
  function automatic logic [ECC_W-1:0] ecc_of(input logic [FRAME_W-1:0] v);
    logic [ECC_W-1:0] e;
    e = '0;
    for (int i = 0; i < FRAME_W; i++) e ^= v[i] ? ECC_W'(i + 1) : '0;
    return e;
  endfunction : ecc_of
  function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] r, input logic [FRAME_W-1:0] d);
    for (int i = FRAME_W - 1; i >= 0; i--) r = {r[CRC_W-2:0], 1'b0} ^ ((r[CRC_W-1] ^ d[i]) ? CRC_POLY : '0);
    return r;
  endfunction : crc_step
  // ==========================================
  // Scenarios
  initial begin
    void'($urandom(8112));
    // Every width code; odd codes send a spoiled key first
    for (int w = 0; w < 4; w++) begin
      do_reset(2'(w), !w[0]);
      if (w[0]) u_cps_host_model.send_key(KEY_WORDS, 1'b1, w == 3);
      else begin
        @(posedge clock_in);
        #1;
        chk("port", active_port_out, PORT_MASTER);
      end
      wait_out(0, PORT_MASTER);
      chk("lanes", flash_lanes_out, (w == 3) ? WIDTH_X1 : 2'(w));
      chk("init_oe", init_status_pin_oe_out, 1'b1);
    end
    pulse(1'b0, 1'b0);
    wait_out(1, 2'h0);
    pulse(1'b1, 1'b0);
    chk("image", boot_image_out, IMG_NEW);
    chk("frozen", io_frozen_out, 1'b1);
    pulse(1'b0, 1'b1);
    chk("image", boot_image_out, IMG_GOLDEN);
    chk("port", active_port_out, PORT_MASTER);
    pulse(1'b0, 1'b0);
    wait_out(1, 2'h0);
    chk("frozen", io_frozen_out, 1'b0);
    // Slave activation; later keys and a bare scan command are ignored
    do_reset(2'h0, 1'b0);
    u_cps_host_model.send_key(KEY_WORDS, 1'b0, 1'b0);
    wait_out(0, PORT_SLAVE);
    @(posedge clock_in);
    scan_command_in <= 1'b1;
    io_freeze_update_in <= 1'b0;
    u_cps_host_model.send_key(KEY_WORDS, 1'b1, 1'b0);
    #1;
    chk("port", active_port_out, PORT_SLAVE);
    chk("frozen", io_frozen_out, 1'b0);
    for (int g = 1; g >= 0; g--) begin
      @(posedge clock_in);
      config_pins_gpio_in <= g[0];
      repeat (4) @(posedge clock_in);
      #1;
      chk("init_oe", init_status_pin_oe_out, !g[0]);
    end
    pulse(1'b0, 1'b0);
    wait_out(1, 2'h0);
    @(posedge clock_in);
    sed_enable_in <= 1'b1;
    wait_out(2, 2'h0);
    // Scan 0: single, double, masked single, clean; scans 1-2 clean, CRC good then bad
    for (int s = 0; s < 3; s++) begin
      c = CRC_SEED;
      for (int f = 0; f < FRAMES; f++) begin
        fr_d[f] = $urandom;
        fr_x[f] = (s > 0 || f == 3) ? '0 : (f == 1) ? 32'h8000_0000 | (32'h1 << ($urandom % 31)) : 32'h1 << ($urandom % 32);
        c = (f == 2) ? c : crc_step(c, fr_d[f]);
      end
      for (int f = 0; f < FRAMES; f++) begin
        chk("addr", frame_addr_out, f);
        @(posedge clock_in);
        crc_expected_in <= (s == 2) ? c ^ 16'h1 : c;
        frame_data_in <= fr_d[f] ^ fr_x[f];
        frame_ecc_in <= ecc_of(fr_d[f]);
        frame_user_mem_in <= (f == 2);
        frame_valid_in <= 1'b1;
        @(posedge clock_in);
        frame_valid_in <= 1'b0;
        #1;
        syn = (f == 2) ? '0 : ecc_of(fr_x[f]);
        chk("sed_err", sed_error_out, syn != 0);
        chk("write", frame_write_out, syn != 0 && syn <= 32);
        chk("uncorr", sed_uncorrectable_out, syn > 32);
        if (syn != 0 && syn <= 32) chk("wdata", frame_wdata_out, fr_d[f]);
      end
      if (s > 0) chk("crc", crc_error_out, s == 2);
      repeat (4) begin
        @(posedge clock_in);
        #1;
        chk("crc_pulse", crc_error_out, 1'b0);
      end
    end
    @(posedge clock_in);
    scan_enable_pin_in <= 1'b1;
    wait_out(0, PORT_SCAN);
    @(posedge clock_in);
    scan_enable_pin_in <= 1'b0;
    wait_out(1, 2'h0);
    report_and_stop();
  end
endmodule : config_port_select_and_seu_scrub_test
